// ==== verilog/tpcs_clock_gen.v ====
// Two-phase non-overlapping processor clock generator with refresh freeze
// and slow-memory stretch of the second phase.
// Assumes one free-running system clock; request and ready pins are
// asynchronous and are synchronised here before use.
`timescale 1ns/1ps
`include "tpcs_map.vh"

// Function
// - The two processor phases are never high at the same time.
// - Refresh request is sampled where the first phase would rise.
// - A request seen low holds the first phase high, the second low.
// - A refresh freeze lasts at least one whole processor period.
// - The refresh grant is high for as long as the freeze lasts.
// - A raised request is taken at the next first-phase rise instant.
// - The asynchronous refresh request is captured before it is used.
// - Memory ready is sampled where the second phase would rise.
// - A ready seen low holds the first phase low, the second high.
// - The stretch lasts until the slow memory controller raises ready.
// - The bus copy of the second phase follows the processor phase.
// - The dynamic-memory clock rises one gap ahead of the second phase.
// - Only the processor takes the second phase; others use the copy.
module tpcs_clock_gen (
  input  wire clk,
  input  wire rst_n,
  input  wire refresh_req_n,
  input  wire mem_ready,
  output reg  cpu_ph1,
  output reg  cpu_ph2,
  output reg  bus_ph2,
  output reg  dram_clk,
  output reg  refresh_grant,
  output reg  stretch_active
);

  localparam integer PH1_CYC = `TPCS_PH1_CYC;
  localparam integer PH2_CYC = `TPCS_PH2_CYC;
  localparam integer GAP_CYC = `TPCS_GAP_CYC;
  localparam integer FRZ_CYC = `TPCS_FRZ_CYC;

  localparam [2:0] ST_PH1  = `TPCS_ST_PH1;
  localparam [2:0] ST_GAP1 = `TPCS_ST_GAP1;
  localparam [2:0] ST_PH2  = `TPCS_ST_PH2;
  localparam [2:0] ST_STR  = `TPCS_ST_STR;
  localparam [2:0] ST_GAP2 = `TPCS_ST_GAP2;
  localparam [2:0] ST_FRZ  = `TPCS_ST_FRZ;

  wire [1:0] pin_in;
  wire [1:0] pin_sync;
  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg  [4:0] cnt_reg;
  reg  [4:0] cnt_next;
  wire       req_low;
  wire       rdy_high;
  wire       cnt_done;

  // Load value for the dwell counter on entry to a state.
  function [4:0] tpcs_load;
    input [2:0] st;
    begin
      case (st)
        ST_PH1: begin
          tpcs_load = PH1_CYC[4:0] - 5'h01;
        end
        ST_PH2: begin
          tpcs_load = PH2_CYC[4:0] - 5'h01;
        end
        ST_GAP1: begin
          tpcs_load = GAP_CYC[4:0] - 5'h01;
        end
        ST_GAP2: begin
          tpcs_load = GAP_CYC[4:0] - 5'h01;
        end
        ST_STR: begin
          // A stretch has no dwell of its own; only ready ends it.
          tpcs_load = 5'h00;
        end
        ST_FRZ: begin
          tpcs_load = FRZ_CYC[4:0] - 5'h01;
        end
        default: begin
          tpcs_load = 5'h00;
        end
      endcase
    end
  endfunction

  // First phase is high in its own state and while frozen.
  function tpcs_ph1_on;
    input [2:0] st;
    begin
      case (st)
        ST_PH1: begin
          tpcs_ph1_on = 1'b1;
        end
        ST_FRZ: begin
          // Held high through the freeze so the core sees no edge.
          tpcs_ph1_on = 1'b1;
        end
        ST_GAP1: begin
          tpcs_ph1_on = 1'b0;
        end
        ST_PH2: begin
          tpcs_ph1_on = 1'b0;
        end
        ST_STR: begin
          tpcs_ph1_on = 1'b0;
        end
        ST_GAP2: begin
          tpcs_ph1_on = 1'b0;
        end
        default: begin
          tpcs_ph1_on = 1'b0;
        end
      endcase
    end
  endfunction

  // Second phase is high in its own state and while stretched.
  function tpcs_ph2_on;
    input [2:0] st;
    begin
      case (st)
        ST_PH2: begin
          tpcs_ph2_on = 1'b1;
        end
        ST_STR: begin
          // Held high while slow memory is not yet ready.
          tpcs_ph2_on = 1'b1;
        end
        ST_PH1: begin
          tpcs_ph2_on = 1'b0;
        end
        ST_GAP1: begin
          tpcs_ph2_on = 1'b0;
        end
        ST_GAP2: begin
          tpcs_ph2_on = 1'b0;
        end
        ST_FRZ: begin
          tpcs_ph2_on = 1'b0;
        end
        default: begin
          tpcs_ph2_on = 1'b0;
        end
      endcase
    end
  endfunction

  // Memory clock opens during the gap before the second phase.
  function tpcs_dram_on;
    input [2:0] st;
    begin
      case (st)
        ST_GAP1: begin
          tpcs_dram_on = 1'b1;
        end
        ST_PH2: begin
          tpcs_dram_on = 1'b1;
        end
        ST_STR: begin
          tpcs_dram_on = 1'b1;
        end
        ST_PH1: begin
          tpcs_dram_on = 1'b0;
        end
        ST_GAP2: begin
          tpcs_dram_on = 1'b0;
        end
        ST_FRZ: begin
          tpcs_dram_on = 1'b0;
        end
        default: begin
          tpcs_dram_on = 1'b0;
        end
      endcase
    end
  endfunction

  // Both pins come from other clock domains, so each meets two flip-flops
  // before any decision reads it.
  // Both reset to one, the idle level, so no false request follows reset.
  assign pin_in = {mem_ready, refresh_req_n};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      reg [1:0] stage_reg;
      always @(posedge clk) begin
        if (!rst_n) begin
          stage_reg <= `TPCS_SYNC_RST;
        end else begin
          stage_reg <= {stage_reg[0], pin_in[gi]};
        end
      end
      assign pin_sync[gi] = stage_reg[1];
    end
  endgenerate

  assign req_low  = ~pin_sync[0];
  assign rdy_high = pin_sync[1];
  assign cnt_done = (cnt_reg == 5'h00);

  // Sequencer. Stretches are only entered at a phase rising instant and
  // only left back into the same phase, so one stretch always completes
  // before the other can be looked at.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_PH1: begin
        if (cnt_done) begin
          state_next = ST_GAP1;
        end
      end
      ST_GAP1: begin
        if (cnt_done) begin
          if (!rdy_high) begin
            state_next = ST_STR;
          end else begin
            state_next = ST_PH2;
          end
        end
      end
      ST_STR: begin
        if (rdy_high) begin
          state_next = ST_PH2;
        end
      end
      ST_PH2: begin
        if (cnt_done) begin
          state_next = ST_GAP2;
        end
      end
      ST_GAP2: begin
        if (cnt_done) begin
          if (req_low) begin
            state_next = ST_FRZ;
          end else begin
            state_next = ST_PH1;
          end
        end
      end
      ST_FRZ: begin
        // The freeze is checked again only after a full period has gone
        // by, which is the next rising instant of the first phase.
        if (cnt_done && !req_low) begin
          state_next = ST_PH1;
        end
      end
      default: begin
        state_next = `TPCS_STATE_RST;
      end
    endcase
  end

  // Dwell counter: reloaded on every state entry and on a repeated freeze.
  always @* begin
    cnt_next = cnt_reg;
    if (state_next != state_reg) begin
      cnt_next = tpcs_load(state_next);
    end else if (cnt_done && state_reg == ST_FRZ) begin
      cnt_next = tpcs_load(ST_FRZ);
    end else if (!cnt_done) begin
      cnt_next = cnt_reg - 5'h01;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= `TPCS_STATE_RST;
      cnt_reg   <= `TPCS_CNT_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Every output is decoded from the next state and registered, so all of
  // them change on the same edge and no combinational glitch reaches a pin.
  always @(posedge clk) begin
    if (!rst_n) begin
      cpu_ph1        <= `TPCS_OUT_RST;
      cpu_ph2        <= `TPCS_OUT_RST;
      bus_ph2        <= `TPCS_OUT_RST;
      dram_clk       <= `TPCS_OUT_RST;
      refresh_grant  <= `TPCS_OUT_RST;
      stretch_active <= `TPCS_OUT_RST;
    end else begin
      cpu_ph1  <= tpcs_ph1_on(state_next);
      cpu_ph2  <= tpcs_ph2_on(state_next);
      // A separate flop keeps the system load off the processor phase.
      bus_ph2  <= tpcs_ph2_on(state_next);
      dram_clk <= tpcs_dram_on(state_next);
      refresh_grant  <= (state_next == ST_FRZ);
      stretch_active <= (state_next == ST_STR);
    end
  end

endmodule

// ==== verilog/tpcs_map.vh ====
// Constants for the two-phase processor clock generator with stretching.
// Assumes a 20 MHz system clock; every figure here is shared by the design.
`ifndef TPCS_MAP_VH
`define TPCS_MAP_VH

// System clock period.
`define TPCS_CLK_PERIOD_NS   50

// Least high times of the processor phases and of each non-overlap gap.
`define TPCS_PH1_HIGH_NS     460
`define TPCS_PH2_HIGH_NS     465
`define TPCS_GAP_NS          50

// Cycle counts, rounded up because each figure is a least time.
`define TPCS_PH1_CYC  \
  ((`TPCS_PH1_HIGH_NS + `TPCS_CLK_PERIOD_NS - 1) / `TPCS_CLK_PERIOD_NS)
`define TPCS_PH2_CYC  \
  ((`TPCS_PH2_HIGH_NS + `TPCS_CLK_PERIOD_NS - 1) / `TPCS_CLK_PERIOD_NS)
`define TPCS_GAP_CYC  \
  ((`TPCS_GAP_NS + `TPCS_CLK_PERIOD_NS - 1) / `TPCS_CLK_PERIOD_NS)

// A refresh freeze lasts one whole processor clock period.
`define TPCS_FRZ_CYC  (`TPCS_PH1_CYC + `TPCS_PH2_CYC + 2 * `TPCS_GAP_CYC)

// Sequencer state codes.
`define TPCS_ST_PH1   3'h0
`define TPCS_ST_GAP1  3'h1
`define TPCS_ST_PH2   3'h2
`define TPCS_ST_STR   3'h3
`define TPCS_ST_GAP2  3'h4
`define TPCS_ST_FRZ   3'h5

// Reset values.
`define TPCS_STATE_RST  3'h4
`define TPCS_CNT_RST    5'h00
`define TPCS_SYNC_RST   2'h3
`define TPCS_OUT_RST    1'h0

`endif

// ==== bench/tpcs_clock_gen_assertions.sv ====
// Checker for the clock generator outputs.
// Bound to the generator by the bench; sees its ports only.
`timescale 1ns/1ps
module tpcs_clock_gen_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic refresh_req_n,
  input wire logic mem_ready,
  input wire logic cpu_ph1,
  input wire logic cpu_ph2,
  input wire logic bus_ph2,
  input wire logic dram_clk,
  input wire logic refresh_grant,
  input wire logic stretch_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence ph1_hold; cpu_ph1[*8]; endsequence
  sequence ph2_hold; cpu_ph2[*8]; endsequence
  chk_no_overlap: assert property (!(cpu_ph1 && cpu_ph2))
    else $error("phases overlap");
  chk_freeze_start: assert property ($rose(refresh_grant) |->
    $rose(cpu_ph1)) else $error("grant off phase one rise");
  chk_freeze_hold: assert property (refresh_grant |->
    cpu_ph1 && !cpu_ph2) else $error("phases move in freeze");
  chk_freeze_len: assert property ($rose(refresh_grant) |->
    ##21 refresh_grant) else $error("freeze too short");
  chk_freeze_exit: assert property ($fell(refresh_grant) |->
    ph1_hold) else $error("phase one cut after freeze");
  chk_stretch_start: assert property ($rose(stretch_active) |->
    $rose(cpu_ph2)) else $error("stretch off phase two rise");
  chk_stretch_hold: assert property (stretch_active |->
    cpu_ph2 && !cpu_ph1) else $error("phases move in stretch");
  chk_stretch_exit: assert property ($fell(stretch_active) |->
    ph2_hold) else $error("phase two cut after stretch");
  chk_bus_copy: assert property (bus_ph2 == cpu_ph2)
    else $error("bus copy differs");
  chk_mem_lead: assert property ($rose(cpu_ph2) |->
    $past(dram_clk) && dram_clk) else $error("memory clock late");
  chk_one_stretch: assert property (
    !(refresh_grant && stretch_active))
    else $error("freeze and stretch together");
endmodule

// ==== bench/tpcs_mem_partner.sv ====
// Refresh and slow memory controllers on the far side.
// Idle lines rest high, as their pull-ups would hold them.
`timescale 1ns/1ps
module tpcs_mem_partner (
  input  wire       clk,
  input  wire       ask_refresh,
  input  wire       ask_slow,
  input  wire [7:0] slow_len,
  input  wire       refresh_grant,
  input  wire       cpu_ph2,
  output reg        refresh_req_n = 1'b1,
  output reg        mem_ready = 1'b1
);
  reg [7:0] held_reg = 8'h00;
  // Outputs move 1 ns off the edge, unrelated to the phase sampling.
  always @(posedge clk) begin
    if (refresh_grant)
      refresh_req_n <= #1 1'b1;
    else if (ask_refresh)
      refresh_req_n <= #1 1'b0;
    if (ask_slow) begin
      mem_ready <= #1 1'b0;
      held_reg <= 8'h00;
    end else if (!mem_ready && cpu_ph2) begin
      held_reg <= held_reg + 8'h01;
      if (held_reg + 8'h01 >= slow_len)
        mem_ready <= #1 1'b1;
    end
  end
endmodule

// ==== bench/tpcs_clock_gen_bench.sv ====
// Bench for the clock generator with a memory-side partner.
// Inputs change 1 ns after each rising edge.
`timescale 1ns/1ps
module tpcs_clock_gen_bench;
  reg  clk = 0, rst_n = 0, ask_refresh = 0, ask_slow = 0;
  wire refresh_req_n, mem_ready, cpu_ph1, cpu_ph2, bus_ph2, dram_clk;
  wire refresh_grant, stretch_active;
  int  n_fail = 0, comparisons = 0, cycles = 0, n;
  always #25 clk = ~clk;
  tpcs_clock_gen tpcs_clock_gen_i (.clk, .rst_n, .refresh_req_n,
    .mem_ready, .cpu_ph1, .cpu_ph2, .bus_ph2, .dram_clk,
    .refresh_grant, .stretch_active);
  tpcs_mem_partner tpcs_mem_partner_i (.clk, .ask_refresh, .ask_slow,
    .slow_len(8'h0F), .refresh_grant, .cpu_ph2, .refresh_req_n,
    .mem_ready);
  task check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task conclude;
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      conclude;
    end
  end
  task tick;
    @(posedge clk);
    #1;
  endtask
  function logic pick(input int s);
    case (s)
      0: pick = cpu_ph1;
      1: pick = cpu_ph2;
      2: pick = refresh_grant;
      default: pick = stretch_active;
    endcase
  endfunction
  // Measures the next whole high pulse, so a pulse in flight is skipped.
  task high_len(input int s);
    n = 0;
    repeat (99) if (pick(s) === 1'b1) tick;
    repeat (99) if (pick(s) !== 1'b1) tick;
    while (pick(s) === 1'b1 && n < 200) begin
      tick;
      n++;
    end
  endtask
  task ask(input logic r, input logic sl, input int s);
    repeat (99) if (pick(s) !== 1'b1) tick;
    ask_refresh = r;
    ask_slow = sl;
    tick;
    ask_refresh = 1'b0;
    ask_slow = 1'b0;
  endtask
  task t_normal;
    high_len(0);
    check("ph1 width", n, 10);
    high_len(1);
    check("ph2 width", n, 10);
  endtask
  task t_refresh;
    ask(1'b1, 1'b0, 1);
    high_len(0);
    check("frozen ph1", n, 32);
  endtask
  task t_stretch;
    ask(1'b0, 1'b1, 0);
    high_len(3);
    check("stretch len", n >= 15 && n <= 20, 1);
  endtask
  task t_both;
    ask(1'b1, 1'b1, 1);
    high_len(2);
    check("grant len", n, 22);
    repeat (60) tick;
  endtask
  task t_reset;
    rst_n = 1'b0;
    repeat (2) tick;
    check("reset outs", {cpu_ph1, cpu_ph2, bus_ph2, dram_clk,
      refresh_grant, stretch_active}, 6'h00);
    rst_n = 1'b1;
  endtask
  initial begin
    repeat (12) tick;
    rst_n = 1'b1;
    t_normal;
    t_refresh;
    t_stretch;
    t_both;
    t_reset;
    t_normal;
    conclude;
  end
endmodule
bind tpcs_clock_gen tpcs_clock_gen_assertions tpcs_clock_gen_assertions_i (
  .clk, .rst_n, .refresh_req_n, .mem_ready, .cpu_ph1, .cpu_ph2,
  .bus_ph2, .dram_clk, .refresh_grant, .stretch_active);
